// ===== ums_uart_extra.sv
// Extra-feature, line-error and modem-status logic with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "ums_defines.svh"
module ums_uart_extra (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Receive FIFO events from the core
  input wire logic rxf_push,
  input wire logic rxf_push_err,
  input wire logic rxf_pop,
  input wire logic rxf_head_valid,
  input wire logic rxf_head_new,
  input wire logic [2:0] rxf_head_err,
  input wire logic rxf_above_trig,
  // Transmitter link from the core
  input wire logic tx_serial,
  input wire logic tx_busy,
  input wire logic tx_bit_start,
  input wire logic baud16_tick,
  output logic tx_hold,
  output logic tx_resume,
  // Serial data to the receiver core
  output logic rx_serial,
  // Interrupt requests to the core
  output logic lsr_irq,
  output logic msr_irq,
  // Modem pins, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  input wire logic rx_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic op1_n,
  output logic op2_n,
  output logic tx_pin,
  // Infrared pins
  input wire logic ir_rx,
  output logic ir_tx
);
  import ums_pkg::*;
  localparam int NPIN = 6;
  localparam int ERRW = 6;

  // Register offset decoder, shared by both paths
  function automatic logic [3:0] reg_index(input logic [4:0] a);
    reg_index = {1'b0, a[4:2]};
  endfunction

  // Registers
  ums_byte_t modem_control_reg; // Modem control
  ums_byte_t interrupt_enable_reg; // Interrupt enables
  ums_byte_t enhanced_feature_reg; // Enhanced features
  ums_byte_t extra_feature_reg; // Extra features, write only
  ums_byte_t infrared_pulse_width_reg; // Pulse width, write only
  ums_byte_t line_status_reg; // Line status image
  ums_byte_t modem_line_status_reg; // Modem status image

  // Write path holding
  logic aw_held; // Address captured
  logic w_held; // Data captured
  logic [4:0] awaddr_q; // Captured address
  logic [7:0] wdata_q; // Captured low byte
  logic wlane_q; // Low lane enabled
  logic do_write; // Both halves present
  logic [3:0] widx; // Write register index
  logic [3:0] ridx; // Read register index
  logic rd_take; // Read address accepted
  logic rd_lsr; // Line status read pulse
  logic rd_msr; // Modem status read pulse

  // Pin synchronisers: cts, dsr, ri, cd, rx, ir
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;

  // Line error state
  logic [ERRW-1:0] err_count; // Error entries held in FIFO
  logic lsr_flag; // Sticky error event

  // Modem status inputs
  logic loop_en; // Local loopback active
  logic ir_en; // Infrared routing active
  logic [3:0] msr_cur; // cd, ri, dsr, cts active high

  // Infrared receive decoder
  ums_ir_state_t ir_state;
  logic [4:0] ir_ticks; // Ticks left in decoded space
  logic ir_pulse; // Pulse seen on the receive pin
  logic ir_rx_data; // Decoded serial level
  logic ir_tx_raw; // Encoder output

  // Synchroniser pins gathered for the loop
  assign pin_raw = {ir_rx, rx_pin, cd_n, ri_n, dsr_n, cts_n};

  // Two flip-flop synchroniser for every pin input
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
        end else if (ce) begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Bus handshakes
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign widx = reg_index(awaddr_q);
  assign ridx = reg_index(araddr);
  assign rd_take = arvalid && arready && ce;
  assign rd_lsr = rd_take && ridx == `UMS_OFF_LSR;
  assign rd_msr = rd_take && ridx == `UMS_OFF_MSR;

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wdata_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (widx <= `UMS_OFF_INFRARED_PULSE_WIDTH_REG) ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Software-written registers; enhanced bits locked unless enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_control_reg <= `UMS_RST_REG;
      interrupt_enable_reg <= `UMS_RST_REG;
      enhanced_feature_reg <= `UMS_RST_REG;
      extra_feature_reg <= `UMS_RST_REG;
      infrared_pulse_width_reg <= `UMS_RST_REG;
    end else if (ce && do_write && wlane_q) begin
      case (widx)
        `UMS_OFF_MCR: begin
          modem_control_reg[4:0] <= wdata_q[4:0];
          if (enhanced_feature_reg[`UMS_EFR_ENH]) begin
            modem_control_reg[7:5] <= wdata_q[7:5];
          end
        end
        `UMS_OFF_IER: begin
          interrupt_enable_reg[3:0] <= wdata_q[3:0];
          if (enhanced_feature_reg[`UMS_EFR_ENH]) begin
            interrupt_enable_reg[7:4] <= wdata_q[7:4];
          end
        end
        `UMS_OFF_EFR: begin
          enhanced_feature_reg <= wdata_q;
        end
        `UMS_OFF_XFR: begin
          // Upper two bits stored as zero
          if (enhanced_feature_reg[`UMS_EFR_ENH]) begin
            extra_feature_reg <= {2'b00, wdata_q[5:0]};
          end
        end
        `UMS_OFF_INFRARED_PULSE_WIDTH_REG: begin
          if (enhanced_feature_reg[`UMS_EFR_ENH]) begin
            infrared_pulse_width_reg <= wdata_q;
          end
        end
        default: begin
          // Other offsets store nothing
        end
      endcase
    end
  end

  // Read data; write-only registers read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (ce) begin
      if (rd_take) begin
        rvalid <= 1'b1;
        rresp <= 2'h0;
        case (ridx)
          `UMS_OFF_MCR: rdata <= {24'h000000, modem_control_reg};
          `UMS_OFF_IER: rdata <= {24'h000000, interrupt_enable_reg};
          `UMS_OFF_EFR: rdata <= {24'h000000, enhanced_feature_reg};
          `UMS_OFF_XFR: rdata <= 32'h00000000;
          `UMS_OFF_INFRARED_PULSE_WIDTH_REG: rdata <= 32'h00000000;
          `UMS_OFF_LSR: rdata <= {24'h000000, line_status_reg};
          `UMS_OFF_MSR: rdata <= {24'h000000, modem_line_status_reg};
          default: begin
            rdata <= 32'h00000000;
            rresp <= 2'h2;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Count erroneous entries held in the receive FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_count <= '0;
    end else if (ce) begin
      case ({rxf_push && rxf_push_err, rxf_pop && rxf_head_valid && (|rxf_head_err)})
        2'b10: err_count <= err_count + 1'b1;
        2'b01: err_count <= err_count - 1'b1;
        default: err_count <= err_count;
      endcase
    end
  end

  // Line status image: summary, error kinds at read position, data ready
  assign line_status_reg = {(err_count != '0), 2'b00, rxf_head_err & {3{rxf_head_valid}}, 1'b0,
                            rxf_head_valid};

  // Receive error event, early or at read position; set wins over read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lsr_flag <= 1'b0;
    end else if (ce) begin
      if ((rxf_head_new && rxf_head_valid && (|rxf_head_err)) ||
          (extra_feature_reg[`UMS_XFR_BADNOW] && rxf_push && rxf_push_err)) begin
        lsr_flag <= 1'b1;
      end else if (rd_lsr) begin
        lsr_flag <= 1'b0;
      end
    end
  end

  // Line status interrupt request
  assign lsr_irq = lsr_flag && interrupt_enable_reg[`UMS_IER_LSR];

  // Mode bits
  assign loop_en = modem_control_reg[`UMS_MCR_LOOP];
  assign ir_en = modem_control_reg[`UMS_MCR_IR];

  // Status sources: inverted pins, or control bits in loopback
  assign msr_cur = loop_en ? {modem_control_reg[`UMS_MCR_OP2], modem_control_reg[`UMS_MCR_OP1],
                              modem_control_reg[`UMS_MCR_DTR], modem_control_reg[`UMS_MCR_RTS]}
                           : ~pin_sync[3:0];

  // Change flags and modem status image
  ums_modem_status u_msr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .cur(msr_cur),
    .rd_clear(rd_msr),
    .status(modem_line_status_reg)
  );

  // Modem status interrupt request
  assign msr_irq = (|modem_line_status_reg[3:0]) && interrupt_enable_reg[`UMS_IER_MSR];

  // Infrared pulse: inverted input idles high
  assign ir_pulse = pin_sync[5] ^ extra_feature_reg[`UMS_XFR_IRINV] &&
                    !(extra_feature_reg[`UMS_XFR_HDX] && tx_busy);

  // Decoder stretches each pulse to one zero bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_state <= UMS_IR_IDLE;
      ir_ticks <= 5'h00;
    end else if (ce) begin
      case (ir_state)
        UMS_IR_IDLE: begin
          if (ir_en && ir_pulse) begin
            ir_state <= UMS_IR_SPACE;
            ir_ticks <= `UMS_BIT_TICKS;
          end
        end
        UMS_IR_SPACE: begin
          if (!ir_en) begin
            ir_state <= UMS_IR_IDLE;
          end else if (baud16_tick) begin
            if (ir_ticks == 5'h01) begin
              ir_state <= UMS_IR_IDLE;
            end
            ir_ticks <= ir_ticks - 5'h01;
          end
        end
        default: ir_state <= UMS_IR_IDLE;
      endcase
    end
  end

  // Decoded level is low during a stretched space
  assign ir_rx_data = (ir_state == UMS_IR_IDLE);

  // Receiver input selection
  assign rx_serial = loop_en ? tx_serial : (ir_en ? ir_rx_data : pin_sync[4]);

  // Infrared transmit encoder
  ums_ir_encoder u_enc (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(ir_en && !loop_en),
    .bit_start(tx_bit_start),
    .tx_bit(tx_serial),
    .baud16_tick(baud16_tick),
    .pulse_width(infrared_pulse_width_reg),
    .ir_tx(ir_tx_raw)
  );

  // Serial pins; infrared output idles low, loopback holds marks
  assign ir_tx = ir_tx_raw;
  assign tx_pin = (loop_en || ir_en) ? 1'b1 : tx_serial;

  // Request-to-send pin: RS-485 direction, auto flow or plain bit
  always_comb begin
    if (loop_en) begin
      rts_n = 1'b1;
    end else if (extra_feature_reg[`UMS_XFR_485]) begin
      if (extra_feature_reg[`UMS_XFR_485INV]) begin
        rts_n = modem_control_reg[`UMS_MCR_RTS] ? !tx_busy : 1'b1;
      end else begin
        rts_n = tx_busy;
      end
    end else if (enhanced_feature_reg[`UMS_EFR_ARTS] && rxf_above_trig) begin
      rts_n = 1'b1;
    end else begin
      rts_n = !modem_control_reg[`UMS_MCR_RTS];
    end
  end

  // Other modem outputs, released in loopback
  assign dtr_n = loop_en || !modem_control_reg[`UMS_MCR_DTR];
  assign op1_n = loop_en || !modem_control_reg[`UMS_MCR_OP1];
  assign op2_n = loop_en || !modem_control_reg[`UMS_MCR_OP2];

  // Transmitter pause while auto CTS sees the pin high
  assign tx_hold = enhanced_feature_reg[`UMS_EFR_ACTS] && !msr_cur[0];

  // Any received character resumes under receive software flow control
  assign tx_resume = ce && rxf_push && extra_feature_reg[`UMS_XFR_XANY] &&
                     (|enhanced_feature_reg[1:0]);
endmodule
`default_nettype wire

// ===== ums_defines.svh
// Register offsets, field positions, reset values and timing counts of the modem-status block
`ifndef UMS_DEFINES_SVH
`define UMS_DEFINES_SVH
// Register indices on the register bus, byte offset divided by four
`define UMS_OFF_MCR 4'h0
`define UMS_OFF_IER 4'h1
`define UMS_OFF_EFR 4'h2
`define UMS_OFF_XFR 4'h3
`define UMS_OFF_INFRARED_PULSE_WIDTH_REG 4'h4
`define UMS_OFF_LSR 4'h5
`define UMS_OFF_MSR 4'h6
// Modem control fields
`define UMS_MCR_DTR 0
`define UMS_MCR_RTS 1
`define UMS_MCR_OP1 2
`define UMS_MCR_OP2 3
`define UMS_MCR_LOOP 4
`define UMS_MCR_IR 6
// Interrupt enable fields
`define UMS_IER_LSR 2
`define UMS_IER_MSR 3
// Enhanced feature fields
`define UMS_EFR_ENH 4
`define UMS_EFR_ARTS 6
`define UMS_EFR_ACTS 7
// Extra feature fields
`define UMS_XFR_HDX 0
`define UMS_XFR_IRINV 1
`define UMS_XFR_485 2
`define UMS_XFR_BADNOW 3
`define UMS_XFR_XANY 4
`define UMS_XFR_485INV 5
// Reset values
`define UMS_RST_REG 8'h00
// Standard pulse of 3/16 bit in 16x ticks, bit length in ticks
`define UMS_IR_STD_TICKS 8'h03
`define UMS_BIT_TICKS 5'h10
`endif

// ===== ums_pkg.sv
// Types shared by the modem-status block
package ums_pkg;
  // One register byte
  typedef logic [7:0] ums_byte_t;
  // Infrared receive decoder states
  typedef enum logic [0:0] {UMS_IR_IDLE, UMS_IR_SPACE} ums_ir_state_t;
endpackage

// ===== ums_ir_encoder.sv
// Infrared transmit pulse encoder with programmable width
`timescale 1ns/1ns
`default_nettype none
`include "ums_defines.svh"
module ums_ir_encoder (
  // Clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic enable,
  // Transmit bit stream
  input wire logic bit_start,
  input wire logic tx_bit,
  input wire logic baud16_tick,
  input wire ums_pkg::ums_byte_t pulse_width,
  // Infrared output
  output logic ir_tx
);
  import ums_pkg::*;
  logic [7:0] cnt; // Remaining pulse length
  logic use_ticks; // Count 16x ticks instead of clocks

  // Pulse counter, idle low when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
      use_ticks <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        cnt <= 8'h00;
      end else if (bit_start && !tx_bit) begin
        // Zero bit starts a pulse
        cnt <= (pulse_width == 8'h00) ? `UMS_IR_STD_TICKS : pulse_width;
        use_ticks <= (pulse_width == 8'h00);
      end else if (cnt != 8'h00 && (!use_ticks || baud16_tick)) begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // Output high while the pulse runs
  assign ir_tx = |cnt;
endmodule
`default_nettype wire

// ===== ums_modem_status.sv
// Modem status bits with change flags cleared by a read
`timescale 1ns/1ns
`default_nettype none
`include "ums_defines.svh"
module ums_modem_status (
  // Clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Current status, active high: cd, ri, dsr, cts
  input wire logic [3:0] cur,
  input wire logic rd_clear,
  // Register image
  output ums_pkg::ums_byte_t status
);
  import ums_pkg::*;
  logic [3:0] prev; // Status seen last cycle
  logic [3:0] delta; // Sticky change flags
  logic [3:0] set_ev; // Change events this cycle

  // Toggle detect; ring flags only at end of ring
  always_comb begin
    set_ev = (cur ^ prev) & 4'hB;
    set_ev[2] = prev[2] & ~cur[2];
  end

  // Previous value and flags; set wins over read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 4'h0;
      delta <= 4'h0;
    end else if (ce) begin
      prev <= cur;
      delta <= (delta & {4{~rd_clear}}) | set_ev;
    end
  end

  assign status = {cur, delta};
endmodule
`default_nettype wire

// ===== ums_uart_extra_monitor.sv
// Assertions for the extra-feature block
`timescale 1ns/1ns
`default_nettype none
module ums_uart_extra_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [4:0] awaddr,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [4:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Core and pin signals
  input wire logic rxf_head_valid,
  input wire logic [2:0] rxf_head_err,
  input wire logic tx_serial,
  input wire logic tx_bit_start,
  input wire logic lsr_irq,
  input wire logic msr_irq,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic ir_tx
);
  // Write index
  logic [2:0] wr_idx;
  // Quiet cycles on the modem pins
  logic [2:0] quiet;
  logic [3:0] pins_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write index of the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_idx <= 3'h0;
    end else if (awvalid && awready) begin
      wr_idx <= awaddr[4:2];
    end
  end
  // Saturating quiet count
  always_ff @(posedge aclk) begin
    pins_q <= {cts_n, dsr_n, ri_n, cd_n};
    if (!aresetn || pins_q != {cts_n, dsr_n, ri_n, cd_n}) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready && rdata[31:8] == 24'h0)
    else $error("read answer late or malformed");
  a_ro_slverr: assert property (bvalid && wr_idx >= 3'd5 |-> bresp == 2'b10)
    else $error("read-only write not refused");
  a_msr_clear: assert property (arvalid && arready && araddr[4:2] == 3'd6 && quiet == 3'h7 |=> !msr_irq)
    else $error("modem status read left interrupt");
  a_lsr_layout: assert property (arvalid && arready && araddr[4:2] == 3'd5 |=>
    rdata[6:5] == 2'b00 && !rdata[1] && rdata[0] == $past(rxf_head_valid)
    && rdata[4:2] == $past(rxf_head_err & {3{rxf_head_valid}})) else $error("line status layout wrong");
  a_ir_start: assert property ($rose(ir_tx) |-> $past(tx_bit_start) && !$past(tx_serial))
    else $error("stray infrared pulse");
  a_reset_idle: assert property ($rose(aresetn) |-> rts_n && dtr_n && !ir_tx && !bvalid && !msr_irq && !lsr_irq)
    else $error("outputs not idle after reset");
  // Main scenarios reached
  c_msr_read: cover property (arvalid && arready && araddr[4:2] == 3'd6 && msr_irq);
  c_slverr: cover property (bvalid && bresp == 2'b10);
  c_ir_pulse: cover property ($rose(ir_tx));
endmodule
bind ums_uart_extra ums_uart_extra_monitor u_mon (.aclk, .aresetn, .awvalid, .awready, .awaddr, .bvalid, .bready,
  .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rxf_head_valid, .rxf_head_err, .tx_serial,
  .tx_bit_start, .lsr_irq, .msr_irq, .cts_n, .dsr_n, .ri_n, .cd_n, .rts_n, .dtr_n, .ir_tx);
`default_nettype wire

// ===== ums_far_model.sv
// Far-side modem and infrared module
`timescale 1ns/1ns
`default_nettype none
module ums_far_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requested line states: cd, ri, dsr, cts
  input wire logic [3:0] lvl,
  // Infrared pulse and polarity
  input wire logic ir_fire,
  input wire logic ir_inv,
  // Pins toward the block
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic cd_n,
  output logic rx_pin,
  output logic ir_rx
);
  // Pulse cycles left
  logic [1:0] ir_left;
  initial {cts_n, dsr_n, ri_n, cd_n, rx_pin, ir_rx, ir_left} = 8'hF8;
  // Modem lines follow the request
  always @(posedge aclk) begin
    {cd_n, ri_n, dsr_n, cts_n} <= ~lvl;
    rx_pin <= 1'b1;
  end
  // Infrared line pulses against its idle level
  always @(posedge aclk) begin
    if (!aresetn) begin
      ir_left <= 2'h0;
    end else if (ir_fire) begin
      ir_left <= 2'h3;
    end else if (ir_left != 2'h0) begin
      ir_left <= ir_left - 2'h1;
    end
    ir_rx <= ir_inv ^ (ir_fire || ir_left != 2'h0);
  end
endmodule
`default_nettype wire

// ===== ums_uart_extra_tb.sv
// Bench for the extra-feature block
`timescale 1ns/1ns
`default_nettype none
`include "ums_defines.svh"
module ums_uart_extra_tb;
  import ums_pkg::*;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lvl;
  logic [1:0] bresp, rresp, resp, bcnt;
  logic rxf_push, rxf_push_err, rxf_pop, rxf_head_valid, rxf_head_new, rxf_above_trig;
  logic [2:0] rxf_head_err;
  logic tx_serial, tx_busy, tx_bit_start, baud16_tick, tx_hold, tx_resume, rx_serial, lsr_irq, msr_irq;
  logic cts_n, dsr_n, ri_n, cd_n, rx_pin, rts_n, dtr_n, op1_n, op2_n, tx_pin, ir_rx, ir_tx, ir_fire, ir_inv;
  ums_byte_t rd;
  int err_count, checks, cycles, w;
  // Line steps and expected status
  logic [3:0] lv [4] = '{4'hB, 4'hF, 4'hB, 4'h0};
  ums_byte_t mx [4] = '{8'hBB, 8'hF0, 8'hB4, 8'h0B};
  // Cases: feature, control, sending, rts_n
  logic [17:0] rs [7] = '{{8'h00, 8'h02, 2'b10}, {8'h00, 8'h00, 2'b11}, {8'h04, 8'h00, 2'b11},
    {8'h04, 8'h00, 2'b00}, {8'hC4, 8'h00, 2'b11}, {8'h24, 8'h02, 2'b10}, {8'h24, 8'h02, 2'b01}};
  ums_uart_extra DUT (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rxf_push,
    .rxf_push_err, .rxf_pop, .rxf_head_valid, .rxf_head_new, .rxf_head_err, .rxf_above_trig, .tx_serial,
    .tx_busy, .tx_bit_start, .baud16_tick, .tx_hold, .tx_resume, .rx_serial, .lsr_irq, .msr_irq, .cts_n,
    .dsr_n, .ri_n, .cd_n, .rx_pin, .rts_n, .dtr_n, .op1_n, .op2_n, .tx_pin, .ir_rx, .ir_tx);
  ums_far_model u_far (.aclk, .aresetn, .lvl, .ir_fire, .ir_inv, .cts_n, .dsr_n, .ri_n, .cd_n, .rx_pin, .ir_rx);
  // Clock, tick every fourth cycle, hang limit
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    bcnt <= bcnt + 2'h1;
    baud16_tick <= (bcnt == 2'h3);
    cycles = cycles + 1;
    if (cycles == 10000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_byte(input string nm, input ums_byte_t exp, input ums_byte_t got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write one register
  task automatic wr(input logic [3:0] idx, input ums_byte_t d);
    @(posedge aclk);
    awaddr <= {idx[2:0], 2'b00};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // Read one register
  task automatic rd_reg(input logic [3:0] idx);
    @(posedge aclk);
    araddr <= {idx[2:0], 2'b00};
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] idx, input ums_byte_t exp);
    rd_reg(idx);
    chk_byte(nm, exp, rd);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rxf_push, rxf_push_err, rxf_pop, rxf_head_valid} = '0;
    {rxf_head_new, rxf_above_trig, tx_busy, tx_bit_start, ir_fire, ir_inv, baud16_tick} = '0;
    {awaddr, araddr, wdata, rxf_head_err, lvl, bcnt} = '0;
    {wstrb, ce, tx_serial, err_count, checks, cycles} = {4'hF, 2'b11, 96'h0};
    tick(8);
    aresetn <= 1'b1;
    // Reset image, access kinds
    rchk("msr_reset", `UMS_OFF_MSR, 8'h00);
    wr(`UMS_OFF_MSR, 8'hFF);
    chk_byte("msr_wr_resp", 8'h02, {6'h0, resp});
    rd_reg(4'h7);
    chk_byte("unmapped_resp", 8'h02, {6'h0, resp});
    wr(`UMS_OFF_EFR, 8'h10);
    wr(`UMS_OFF_IER, 8'h0C);
    // Modem line steps
    for (int i = 0; i < 4; i++) begin
      lvl <= lv[i];
      tick(6);
      chk_bit("msr_irq_set", mx[i][3:0] != 4'h0, msr_irq);
      rchk("msr_delta", `UMS_OFF_MSR, mx[i]);
      rchk("msr_clear", `UMS_OFF_MSR, {mx[i][7:4], 4'h0});
      chk_bit("msr_irq_clr", 1'b0, msr_irq);
    end
    // Loopback status
    for (int i = 0; i < 2; i++) begin
      wr(`UMS_OFF_MCR, i ? 8'h15 : 8'h1A);
      tick(5);
      rd_reg(`UMS_OFF_MSR);
      rchk("loop_status", `UMS_OFF_MSR, i ? 8'h60 : 8'h90);
      chk_bit("loop_rts", 1'b1, rts_n);
    end
    wr(`UMS_OFF_MCR, 8'h0D);
    tick(5);
    chk_byte("mdm_out", 8'h01, {4'h0, dtr_n, op1_n, op2_n, tx_pin});
    rd_reg(`UMS_OFF_MSR);
    // RS-485 direction control
    for (int i = 0; i < 7; i++) begin
      wr(`UMS_OFF_XFR, rs[i][17:10]);
      wr(`UMS_OFF_MCR, rs[i][9:2]);
      tx_busy <= rs[i][1];
      tick(3);
      chk_bit("rts_dir", rs[i][0], rts_n);
    end
    tx_busy <= 1'b0;
    rchk("xfr_wo", `UMS_OFF_XFR, 8'h00);
    wr(`UMS_OFF_XFR, 8'h00);
    wr(`UMS_OFF_MCR, 8'h00);
    // Clear-to-send pause and resume
    wr(`UMS_OFF_EFR, 8'h90);
    for (int i = 0; i < 2; i++) begin
      lvl <= {3'h0, i[0]};
      tick(6);
      chk_bit("cts_hold", !i[0], tx_hold);
    end
    // Any character resumes when enabled
    wr(`UMS_OFF_EFR, 8'h1A);
    for (int i = 0; i < 2; i++) begin
      wr(`UMS_OFF_XFR, {3'h0, i[0], 4'h0});
      @(posedge aclk) rxf_push <= 1'b1;
      @(negedge aclk) chk_bit("xon_any", i[0], tx_resume);
      @(posedge aclk) rxf_push <= 1'b0;
    end
    // Bad character interrupt timing
    wr(`UMS_OFF_EFR, 8'h10);
    for (int i = 0; i < 2; i++) begin
      wr(`UMS_OFF_XFR, {4'h0, i[0], 3'h0});
      @(posedge aclk) {rxf_push, rxf_push_err} <= 2'b11;
      @(posedge aclk) {rxf_push, rxf_push_err} <= 2'b00;
      tick(2);
      chk_bit("lsr_arrival", i[0], lsr_irq);
      rchk("lsr_early", `UMS_OFF_LSR, 8'h80);
      chk_bit("lsr_rd_clr", 1'b0, lsr_irq);
      @(posedge aclk) {rxf_head_new, rxf_head_valid, rxf_head_err} <= 5'b11001;
      @(posedge aclk) rxf_head_new <= 1'b0;
      tick(2);
      chk_bit("lsr_head", 1'b1, lsr_irq);
      rchk("lsr_head_rd", `UMS_OFF_LSR, 8'h85);
      @(posedge aclk) rxf_pop <= 1'b1;
      @(posedge aclk) {rxf_pop, rxf_head_valid, rxf_head_err} <= 5'b00000;
      tick(2);
      rchk("lsr_empty", `UMS_OFF_LSR, 8'h00);
    end
    // Infrared receive modes
    wr(`UMS_OFF_MCR, 8'h40);
    for (int i = 0; i < 3; i++) begin
      wr(`UMS_OFF_XFR, (i == 1) ? 8'h02 : {7'h0, i == 2});
      {ir_inv, tx_busy} <= {i == 1, i == 2};
      tick(80);
      chk_bit("ir_idle", 1'b1, rx_serial);
      @(posedge aclk) ir_fire <= 1'b1;
      @(posedge aclk) ir_fire <= 1'b0;
      tick(8);
      chk_bit("ir_rx_bit", i == 2, rx_serial);
    end
    tx_busy <= 1'b0;
    // Infrared transmit pulse widths
    for (int i = 0; i < 2; i++) begin
      wr(`UMS_OFF_INFRARED_PULSE_WIDTH_REG, i ? 8'h00 : 8'h05);
      do @(posedge aclk); while (baud16_tick !== 1'b1);
      {tx_serial, tx_bit_start} <= 2'b01;
      @(posedge aclk) tx_bit_start <= 1'b0;
      w = 0;
      repeat (40) begin
        @(posedge aclk);
        if (ir_tx === 1'b1) w++;
      end
      tx_serial <= 1'b1;
      if (i == 0) chk_byte("ir_width", 8'h05, w[7:0]);
      else chk_bit("ir_std", 1'b1, w >= 9 && w <= 13);
    end
    rchk("infrared_pulse_width_reg_wo", `UMS_OFF_INFRARED_PULSE_WIDTH_REG, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
